/* inc/isp_pkg.sv */
// Package with register map, flag layout, vectors and states of the interrupt prioritizer.
package isp_pkg;

    // Register byte offsets on the bus.
    localparam logic [4:0] ISP_OFF_ENABLE0 = 5'h00;
    localparam logic [4:0] ISP_OFF_ENABLE1 = 5'h04;
    localparam logic [4:0] ISP_OFF_FLAGS = 5'h08;
    localparam logic [4:0] ISP_OFF_PENDING = 5'h0c;
    localparam logic [4:0] ISP_OFF_CPUCTL = 5'h10;
    localparam logic [4:0] ISP_OFF_LASTVEC = 5'h14;

    // Reset values.
    localparam logic [26:0] ISP_RST_ENABLE0 = 27'h0000000;
    localparam logic [5:0] ISP_RST_ENABLE1 = 6'h00;
    localparam logic [8:0] ISP_RST_FLAGS = 9'h000;
    localparam logic ISP_RST_GMASK = 1'b1;

    // Locally held flags, also their positions in the flags register.
    localparam int ISP_FL_EXT = 0;
    localparam int ISP_FL_LOCK = 1;
    localparam int ISP_FL_TMR = 2;
    localparam int ISP_FL_KEY = 8;

    // Enable register 0 field positions.
    localparam int ISP_EN_EXT_MASK = 0;
    localparam int ISP_EN_LOCK = 1;
    localparam int ISP_EN_TMR = 2;
    localparam int ISP_EN_KEY_MASK = 8;
    localparam int ISP_EN_SPI_RX = 9;
    localparam int ISP_EN_SPI_FAULT = 10;
    localparam int ISP_EN_SPI_TX = 11;
    localparam int ISP_EN_SCI_ERR = 12;
    localparam int ISP_EN_SCI_RX = 16;
    localparam int ISP_EN_SCI_IDLE = 17;
    localparam int ISP_EN_SCI_TXE = 18;
    localparam int ISP_EN_SCI_DONE = 19;
    localparam int ISP_EN_ADC = 20;
    localparam int ISP_EN_TB = 21;
    localparam int ISP_EN_CAN_WUP = 22;
    localparam int ISP_EN_CAN_RX = 23;
    localparam int ISP_EN_CAN_TX = 24;

    // Control register field position.
    localparam int ISP_CTL_GMASK = 0;

    // Vectors and priorities.
    localparam logic [15:0] ISP_VEC_RESET = 16'hfffe;
    localparam logic [15:0] ISP_VEC_TRAP = 16'hfffc;
    localparam logic [4:0] ISP_PRIO_TOP = 5'h00;
    localparam int ISP_NUM_PEND = 20;

    // Sequencer states.
    typedef enum logic [1:0] {
        ISP_ST_VEC = 2'b01,
        ISP_ST_RUN = 2'b10
    } isp_state_type;

endpackage

/* logic/isp_prioritizer.sv */
// Interrupt source prioritizer with flag gating, priority select and vector output.
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Overview of operation
// - A break point hit makes the CPU take the software trap vector.
// - Global mask blocks every source except the software trap instruction and a break point hit.
// - Priority 0 is highest; larger numbers are served later.
// - Reset and software trap have priority 0; reset vector is highest.
// - Low external pin latches a flag, masked, pending bit 1.
// - Any change of lock status sets the lock change flag.
// - Lock change flag requests only when enabled; pending bit 2.
// - Timer rollover flag sets when counter wraps to zero after modulo match.
// - First timer rollover requests only while its enable is set.
// - Capture or compare event sets that channel's flag.
// - Channel flag requests only while that channel's enable is set.
// - First timer: channel 0, channel 1, rollover on bits 3, 4, 5.
// - Second timer: channel 0, channel 1, rollover on bits 6, 7, 8.
// - SPI receive, overrun, mode fault share bit 9; transmit empty bit 10.
// - Four SCI error flags, each enabled, share pending bit 11.
// - SCI receive and idle share bit 12; transmit flags share bit 13.
// - Keypad, ADC done and timebase use pending bits 14, 15, 16.
// - CAN wakeup 17, six errors 18, receive 19, three transmit 20.
// - Service starts only at an instruction boundary.
// - With several pending, the highest priority one is served first.
// - Interrupt entry sets the global mask.
module isp_prioritizer
    import isp_pkg::*;
#(
    parameter int ADDR_W = 5
)
(
    // Clock, reset and clock enable.
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Avalon-MM register slave.
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // CPU core.
    input wire logic cpu_insn_done_i,
    input wire logic cpu_software_trap_instruction_i,
    input wire logic brk_hit_i,
    output logic cpu_take_o,
    output logic [15:0] cpu_vector_o,
    output logic [4:0] cpu_prio_o,
    output logic cpu_break_trap_o,
    output logic cpu_gmask_o,
    // Pins and locally flagged events.
    input wire logic ext_request_pin_n_i,
    input wire logic [7:0] keypad_pins_n_i,
    input wire logic lock_status_i,
    input wire logic [1:0] tmr_modulo_match_i,
    input wire logic [1:0] tmr_count_zero_i,
    input wire logic [3:0] tmr_chan_event_i,
    // Peripheral flag levels.
    input wire logic spi_rx_full_flag_i,
    input wire logic spi_rx_overrun_flag_i,
    input wire logic spi_mode_fault_flag_i,
    input wire logic spi_tx_empty_flag_i,
    input wire logic [3:0] sci_err_flags_i,
    input wire logic sci_rx_full_flag_i,
    input wire logic sci_idle_flag_i,
    input wire logic sci_tx_empty_flag_i,
    input wire logic sci_tx_done_flag_i,
    input wire logic adc_done_flag_i,
    input wire logic timebase_rollover_flag_i,
    input wire logic can_wakeup_flag_i,
    input wire logic [5:0] can_err_flags_i,
    input wire logic can_rx_full_flag_i,
    input wire logic [2:0] can_tx_empty_flags_i
);

    // Returns the lowest set pending index, which is the highest priority.
    function automatic logic [4:0] isp_first(input logic [ISP_NUM_PEND:0] p);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = ISP_NUM_PEND; i >= 1; i--)
        begin
            if (p[i])
            begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // Vector of a pending index, two bytes below the software trap per step.
    function automatic logic [15:0] isp_vector(input logic [4:0] idx);
        return ISP_VEC_TRAP - {10'h000, idx, 1'b0};
    endfunction

    isp_state_type state_r, state_nxt;
    logic [26:0] en0_r;
    logic [5:0] en1_r;
    logic [8:0] flag_r, flag_nxt;
    logic [8:0] flag_set;
    logic [8:0] flag_clr;
    logic gmask_r, gmask_nxt;
    logic lock_prev_r;
    logic [1:0] armed_r;
    logic brk_pend_r;
    logic wait_r;
    logic [31:0] rd_r;
    logic take_r, take_nxt;
    logic [15:0] vec_r, vec_nxt;
    logic [4:0] prio_r, prio_nxt;
    logic brk_out_r, brk_out_nxt;

    // Bus decode.
    wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
        {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    wire wr_go = avs_write_i && !wait_r;
    wire [31:0] wr_bits = avs_writedata_i & be_mask;
    wire [31:0] wr_keep = ~be_mask;
    wire wr_en0 = wr_go && (avs_address_i == ISP_OFF_ENABLE0);
    wire wr_en1 = wr_go && (avs_address_i == ISP_OFF_ENABLE1);
    wire wr_flags = wr_go && (avs_address_i == ISP_OFF_FLAGS);
    wire wr_ctl = wr_go && (avs_address_i == ISP_OFF_CPUCTL);

    // Pending bits from flags and enables.
    logic [ISP_NUM_PEND:0] pend;
    assign pend[0] = 1'b0;
    assign pend[1] = flag_r[ISP_FL_EXT] && !en0_r[ISP_EN_EXT_MASK];
    assign pend[2] = flag_r[ISP_FL_LOCK] && en0_r[ISP_EN_LOCK];
    // Timer flags and enables line up bit for bit; rollover at 5 and 8.
    assign pend[8:3] = flag_r[ISP_FL_TMR +: 6] & en0_r[ISP_EN_TMR +: 6];
    assign pend[9] = (spi_rx_full_flag_i && en0_r[ISP_EN_SPI_RX])
        || ((spi_rx_overrun_flag_i || spi_mode_fault_flag_i)
        && en0_r[ISP_EN_SPI_FAULT]);
    assign pend[10] = spi_tx_empty_flag_i && en0_r[ISP_EN_SPI_TX];
    assign pend[11] = |(sci_err_flags_i & en0_r[ISP_EN_SCI_ERR +: 4]);
    assign pend[12] = (sci_rx_full_flag_i && en0_r[ISP_EN_SCI_RX])
        || (sci_idle_flag_i && en0_r[ISP_EN_SCI_IDLE]);
    assign pend[13] = (sci_tx_empty_flag_i && en0_r[ISP_EN_SCI_TXE])
        || (sci_tx_done_flag_i && en0_r[ISP_EN_SCI_DONE]);
    assign pend[14] = flag_r[ISP_FL_KEY] && !en0_r[ISP_EN_KEY_MASK];
    assign pend[15] = adc_done_flag_i && en0_r[ISP_EN_ADC];
    assign pend[16] = timebase_rollover_flag_i && en0_r[ISP_EN_TB];
    assign pend[17] = can_wakeup_flag_i && en0_r[ISP_EN_CAN_WUP];
    assign pend[18] = |(can_err_flags_i & en1_r);
    assign pend[19] = can_rx_full_flag_i && en0_r[ISP_EN_CAN_RX];
    assign pend[20] = |(can_tx_empty_flags_i & en0_r[ISP_EN_CAN_TX +: 3]);

    wire [4:0] first_idx = isp_first(pend);
    wire any_pend = |pend;

    // Local flag set events.
    wire [1:0] tmr_roll = tmr_count_zero_i & armed_r;
    assign flag_set[ISP_FL_EXT] = !ext_request_pin_n_i;
    assign flag_set[ISP_FL_LOCK] = lock_status_i ^ lock_prev_r;
    assign flag_set[ISP_FL_TMR +: 6] = {tmr_roll[1], tmr_chan_event_i[3:2],
        tmr_roll[0], tmr_chan_event_i[1:0]};
    assign flag_set[ISP_FL_KEY] = !(&keypad_pins_n_i);
    assign flag_clr = wr_flags ? wr_bits[8:0] : 9'h000;
    assign flag_nxt = (flag_r & ~flag_clr) | flag_set;

    // Service decision.
    wire boundary = (state_r == ISP_ST_RUN) && cpu_insn_done_i;
    wire trap_req = cpu_software_trap_instruction_i || brk_pend_r || brk_hit_i;
    wire take_trap = boundary && trap_req;
    wire take_irq = boundary && !trap_req && !gmask_r && any_pend;

    always_comb
    begin
        state_nxt = state_r;
        take_nxt = 1'b0;
        vec_nxt = vec_r;
        prio_nxt = prio_r;
        brk_out_nxt = 1'b0;
        unique case (state_r)
            ISP_ST_VEC:
            begin
                take_nxt = 1'b1;
                vec_nxt = ISP_VEC_RESET;
                prio_nxt = ISP_PRIO_TOP;
                state_nxt = ISP_ST_RUN;
            end
            ISP_ST_RUN:
            begin
                if (take_trap)
                begin
                    take_nxt = 1'b1;
                    vec_nxt = ISP_VEC_TRAP;
                    prio_nxt = ISP_PRIO_TOP;
                    brk_out_nxt = brk_pend_r || brk_hit_i;
                end
                else if (take_irq)
                begin
                    take_nxt = 1'b1;
                    vec_nxt = isp_vector(first_idx);
                    prio_nxt = first_idx;
                end
            end
            default:
            begin
                state_nxt = ISP_ST_VEC;
            end
        endcase
    end

    // Entry sets the mask and wins over a software clear in the same cycle.
    assign gmask_nxt = (take_trap || take_irq) ? 1'b1 :
        (wr_ctl ? ((gmask_r & wr_keep[ISP_CTL_GMASK]) | wr_bits[ISP_CTL_GMASK]) :
        gmask_r);

    // Read data selection.
    logic [31:0] rd_word;
    assign rd_word = (avs_address_i == ISP_OFF_ENABLE0) ? {5'h00, en0_r} :
        (avs_address_i == ISP_OFF_ENABLE1) ? {26'h0000000, en1_r} :
        (avs_address_i == ISP_OFF_FLAGS) ? {23'h000000, flag_r} :
        (avs_address_i == ISP_OFF_PENDING) ? {11'h000, pend} :
        (avs_address_i == ISP_OFF_CPUCTL) ? {31'h00000000, gmask_r} :
        (avs_address_i == ISP_OFF_LASTVEC) ? {11'h000, prio_r, vec_r} :
        32'h00000000;

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            state_r <= ISP_ST_VEC;
            en0_r <= ISP_RST_ENABLE0;
            en1_r <= ISP_RST_ENABLE1;
            flag_r <= ISP_RST_FLAGS;
            gmask_r <= ISP_RST_GMASK;
            lock_prev_r <= 1'b0;
            armed_r <= 2'h0;
            brk_pend_r <= 1'b0;
            wait_r <= 1'b1;
            rd_r <= 32'h00000000;
            take_r <= 1'b0;
            vec_r <= ISP_VEC_RESET;
            prio_r <= ISP_PRIO_TOP;
            brk_out_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            state_r <= state_nxt;
            flag_r <= flag_nxt;
            gmask_r <= gmask_nxt;
            lock_prev_r <= lock_status_i;
            armed_r <= (armed_r | tmr_modulo_match_i) & ~tmr_count_zero_i;
            brk_pend_r <= (brk_pend_r || brk_hit_i) && !take_trap;
            take_r <= take_nxt;
            vec_r <= vec_nxt;
            prio_r <= prio_nxt;
            brk_out_r <= brk_out_nxt;
            if (wr_en0)
            begin
                en0_r <= (en0_r & wr_keep[26:0]) | wr_bits[26:0];
            end
            if (wr_en1)
            begin
                en1_r <= (en1_r & wr_keep[5:0]) | wr_bits[5:0];
            end
            if ((avs_read_i || avs_write_i) && wait_r)
            begin
                wait_r <= 1'b0;
                rd_r <= rd_word;
            end
            else
            begin
                wait_r <= 1'b1;
            end
        end
    end

    assign avs_readdata_o = rd_r;
    assign avs_waitrequest_o = wait_r;
    assign cpu_take_o = take_r;
    assign cpu_vector_o = vec_r;
    assign cpu_prio_o = prio_r;
    assign cpu_break_trap_o = brk_out_r;
    assign cpu_gmask_o = gmask_r;

    // Checks.
    property p_brk_trap;
        @(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && boundary && (brk_hit_i || brk_pend_r)
        |=> cpu_take_o && cpu_break_trap_o && (cpu_vector_o == ISP_VEC_TRAP);
    endproperty
    a_brk_trap: assert property (p_brk_trap)
        else $error("Break hit did not produce a software trap entry.");

    property p_trap_unmasked;
        @(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && boundary && cpu_software_trap_instruction_i && gmask_r
        |=> cpu_take_o ##0 cpu_prio_o == ISP_PRIO_TOP;
    endproperty
    a_trap_unmasked: assert property (p_trap_unmasked)
        else $error("Software trap was blocked by the global mask.");

    property p_mask_blocks;
        @(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && boundary && gmask_r && !trap_req |=> !cpu_take_o;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("Masked request was taken.");

    property p_reset_vec;
        @(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && (state_r == ISP_ST_VEC)
        |=> cpu_take_o && (cpu_vector_o == ISP_VEC_RESET) && (cpu_prio_o == ISP_PRIO_TOP);
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("Reset vector was not issued first.");

    property p_ext_latch;
        @(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && !ext_request_pin_n_i |=> flag_r[ISP_FL_EXT];
    endproperty
    a_ext_latch: assert property (p_ext_latch)
        else $error("External pin low did not latch its flag.");

    property p_lock_change;
        @(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && (lock_status_i != lock_prev_r) |=> flag_r[ISP_FL_LOCK];
    endproperty
    a_lock_change: assert property (p_lock_change)
        else $error("Lock change did not set its flag.");

    property p_tmr_roll;
        @(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && tmr_modulo_match_i[0] && !tmr_count_zero_i[0]
        ##1 clk_en_i && tmr_count_zero_i[0] |=> flag_r[ISP_FL_TMR + 2];
    endproperty
    a_tmr_roll: assert property (p_tmr_roll)
        else $error("Timer wrap after match did not set the rollover flag.");

    property p_no_midinsn;
        @(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && (state_r == ISP_ST_RUN) && !cpu_insn_done_i |=> !cpu_take_o;
    endproperty
    a_no_midinsn: assert property (p_no_midinsn)
        else $error("Interrupt taken away from an instruction boundary.");

    property p_highest_first;
        @(posedge core_clk_i) disable iff (reset_i)
        clk_en_i && take_irq |=> cpu_take_o && (cpu_prio_o == $past(first_idx))
        && (cpu_vector_o == ISP_VEC_TRAP - {10'h000, cpu_prio_o, 1'b0});
    endproperty
    a_highest_first: assert property (p_highest_first)
        else $error("Wrong priority or vector chosen.");

    property p_entry_mask;
        @(posedge core_clk_i) disable iff (reset_i)
        cpu_take_o |-> cpu_gmask_o;
    endproperty
    a_entry_mask: assert property (p_entry_mask)
        else $error("Interrupt entry left the global mask clear.");

    property p_cov_irq;
        @(posedge core_clk_i) disable iff (reset_i)
        take_irq && $countones(pend) > 1;
    endproperty
    c_cov_irq: cover property (p_cov_irq);

    property p_cov_brk;
        @(posedge core_clk_i) disable iff (reset_i)
        take_trap && brk_pend_r;
    endproperty
    c_cov_brk: cover property (p_cov_brk);

    property p_cov_wr;
        @(posedge core_clk_i) disable iff (reset_i)
        wr_flags ##[2:3] wr_ctl;
    endproperty
    c_cov_wr: cover property (p_cov_wr);

endmodule

/* tb/isp_cpu_model.sv */
// CPU core model that runs instructions on request and records service entries.
`timescale 1ns/1ps
module isp_cpu_model
(
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Requests from the bench.
    input wire logic step_i,
    input wire logic trap_i,
    // Service entry from the prioritizer.
    input wire logic take_i,
    input wire logic [15:0] vector_i,
    input wire logic [4:0] prio_i,
    input wire logic brk_i,
    // Instruction boundary and records.
    output logic insn_done_o,
    output logic trap_o,
    output logic [7:0] takes_o,
    output logic [15:0] vec_o,
    output logic [4:0] prio_o,
    output logic brk_o
);
    logic [1:0] cnt_r;
    logic trap_r;
    always_ff @(posedge core_clk_i)
    begin
        insn_done_o <= 1'b0;
        trap_o <= 1'b0;
        if (reset_i)
        begin
            cnt_r <= 2'h0;
            takes_o <= 8'h00;
        end
        else
        begin
            if (step_i)
            begin
                cnt_r <= 2'h2;
                trap_r <= trap_i;
            end
            else if (cnt_r != 2'h0)
            begin
                cnt_r <= cnt_r - 2'h1;
                insn_done_o <= (cnt_r == 2'h1);
                trap_o <= trap_r & (cnt_r == 2'h1);
            end
            if (take_i)
            begin
                takes_o <= takes_o + 8'h01;
                vec_o <= vector_i;
                prio_o <= prio_i;
                brk_o <= brk_i;
            end
        end
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the interrupt source prioritizer.
`timescale 1ns/1ps
module testbench;
    import isp_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hf;
    logic ce = 1'b1;
    logic [31:0] rdo, got;
    logic wreq, step = 1'b0, trap = 1'b0, brk = 1'b0, pin_n = 1'b1, lock = 1'b0;
    logic [7:0] key_n = 8'hff;
    logic [1:0] mm = 2'h0, cz = 2'h0;
    logic [3:0] ev = 4'h0;
    logic [24:0] lv = 25'h0;
    logic done, trp, take, btrap, gmask, mbrk;
    logic [15:0] vec, mvec;
    logic [4:0] prio, mprio;
    logic [7:0] takes;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    byte pb[25] = '{9, 9, 9, 10, 11, 11, 11, 11, 12, 12, 13, 13, 15, 16, 17,
                    18, 18, 18, 18, 18, 18, 19, 20, 20, 20};
    isp_prioritizer u_isp_prioritizer (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .clk_en_i(ce), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdo),
        .avs_waitrequest_o(wreq), .cpu_insn_done_i(done),
        .cpu_software_trap_instruction_i(trp), .brk_hit_i(brk), .cpu_take_o(take),
        .cpu_vector_o(vec), .cpu_prio_o(prio), .cpu_break_trap_o(btrap),
        .cpu_gmask_o(gmask), .ext_request_pin_n_i(pin_n), .keypad_pins_n_i(key_n),
        .lock_status_i(lock), .tmr_modulo_match_i(mm), .tmr_count_zero_i(cz),
        .tmr_chan_event_i(ev), .spi_rx_full_flag_i(lv[0]), .spi_rx_overrun_flag_i(lv[1]),
        .spi_mode_fault_flag_i(lv[2]), .spi_tx_empty_flag_i(lv[3]),
        .sci_err_flags_i(lv[7:4]), .sci_rx_full_flag_i(lv[8]), .sci_idle_flag_i(lv[9]),
        .sci_tx_empty_flag_i(lv[10]), .sci_tx_done_flag_i(lv[11]),
        .adc_done_flag_i(lv[12]), .timebase_rollover_flag_i(lv[13]),
        .can_wakeup_flag_i(lv[14]), .can_err_flags_i(lv[20:15]),
        .can_rx_full_flag_i(lv[21]), .can_tx_empty_flags_i(lv[24:22]));
    isp_cpu_model u_isp_cpu_model (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .step_i(step), .trap_i(trap), .take_i(take), .vector_i(vec), .prio_i(prio),
        .brk_i(btrap), .insn_done_o(done), .trap_o(trp), .takes_o(takes),
        .vec_o(mvec), .prio_o(mprio), .brk_o(mbrk));
    initial
    begin
        forever #2 core_clk_i = ~core_clk_i;
    end
    task automatic results();
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        @(posedge core_clk_i);
        while (wreq !== 1'b0)
        begin
            @(posedge core_clk_i);
        end
        got = rdo;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp("register", e, got);
    endtask
    task automatic insn(input logic t, input logic [7:0] nt, input logic [15:0] v,
                        input logic [4:0] p, input logic b);
        logic [7:0] k;
        k = takes;
        step <= 1'b1;
        trap <= t;
        tick(1);
        step <= 1'b0;
        tick(6);
        cmp("takes", {24'h0, k + nt}, {24'h0, takes});
        if (nt != 8'h00)
        begin
            cmp("vector", {16'h0, v}, {16'h0, mvec});
            cmp("prio", {27'h0, p}, {27'h0, mprio});
            cmp("break", {31'h0, b}, {31'h0, mbrk});
            cmp("gmask", 32'h1, {31'h0, gmask});
        end
    endtask
    task automatic t_reset();
        tick(4);
        cmp("reset entry", 32'h0fffe, {11'h0, mprio, mvec});
        rchk(ISP_OFF_CPUCTL, 32'h1);
        rchk(ISP_OFF_ENABLE0, 32'h0);
        rchk(ISP_OFF_FLAGS, 32'h0);
        bus(1'b1, ISP_OFF_PENDING, 32'hffffffff);
        rchk(ISP_OFF_PENDING, 32'h0);
        rchk(5'h18, 32'h0);
        be <= 4'h1;
        bus(1'b1, ISP_OFF_ENABLE0, 32'hffffffff);
        be <= 4'hf;
        rchk(ISP_OFF_ENABLE0, 32'hff);
        bus(1'b1, ISP_OFF_ENABLE0, 32'h0);
        ce <= 1'b0;
        pin_n <= 1'b0;
        tick(3);
        pin_n <= 1'b1;
        ce <= 1'b1;
        tick(1);
        rchk(ISP_OFF_FLAGS, 32'h0);
    endtask
    task automatic t_ext();
        pin_n <= 1'b0;
        tick(2);
        rchk(ISP_OFF_FLAGS, 32'h1);
        rchk(ISP_OFF_PENDING, 32'h2);
        bus(1'b1, ISP_OFF_ENABLE0, 32'h1);
        rchk(ISP_OFF_PENDING, 32'h0);
        bus(1'b1, ISP_OFF_ENABLE0, 32'h0);
        insn(1'b0, 8'h0, 16'h0, 5'h0, 1'b0);
        bus(1'b1, ISP_OFF_CPUCTL, 32'h0);
        insn(1'b0, 8'h1, 16'hfffc - 16'd2, 5'd1, 1'b0);
        rchk(ISP_OFF_CPUCTL, 32'h1);
        rchk(ISP_OFF_LASTVEC, 32'h1fffa);
        insn(1'b1, 8'h1, ISP_VEC_TRAP, 5'd0, 1'b0);
        pin_n <= 1'b1;
        tick(1);
        bus(1'b1, ISP_OFF_FLAGS, 32'h1);
        rchk(ISP_OFF_FLAGS, 32'h0);
        brk <= 1'b1;
        tick(1);
        brk <= 1'b0;
        insn(1'b0, 8'h1, ISP_VEC_TRAP, 5'd0, 1'b1);
    endtask
    task automatic t_prio();
        bus(1'b1, ISP_OFF_ENABLE0, 32'h804);
        ev <= 4'h3;
        lv <= 25'h8;
        tick(1);
        ev <= 4'h0;
        tick(1);
        rchk(ISP_OFF_FLAGS, 32'hc);
        rchk(ISP_OFF_PENDING, 32'h408);
        bus(1'b1, ISP_OFF_CPUCTL, 32'h0);
        insn(1'b0, 8'h1, 16'hfff6, 5'd3, 1'b0);
        bus(1'b1, ISP_OFF_FLAGS, 32'hc);
        bus(1'b1, ISP_OFF_CPUCTL, 32'h0);
        insn(1'b0, 8'h1, 16'hffe8, 5'd10, 1'b0);
        lv <= 25'h0;
        cz <= 2'h1;
        tick(1);
        cz <= 2'h0;
        tick(1);
        rchk(ISP_OFF_FLAGS, 32'h0);
        mm <= 2'h3;
        tick(1);
        mm <= 2'h0;
        cz <= 2'h3;
        tick(1);
        cz <= 2'h0;
        tick(1);
        rchk(ISP_OFF_FLAGS, 32'h90);
        bus(1'b1, ISP_OFF_ENABLE0, 32'h10);
        rchk(ISP_OFF_PENDING, 32'h20);
        bus(1'b1, ISP_OFF_ENABLE0, 32'h80);
        rchk(ISP_OFF_PENDING, 32'h100);
        bus(1'b1, ISP_OFF_FLAGS, 32'h90);
        bus(1'b1, ISP_OFF_ENABLE0, 32'h0);
    endtask
    task automatic t_misc();
        lock <= 1'b1;
        tick(2);
        rchk(ISP_OFF_FLAGS, 32'h2);
        rchk(ISP_OFF_PENDING, 32'h0);
        bus(1'b1, ISP_OFF_ENABLE0, 32'h2);
        rchk(ISP_OFF_PENDING, 32'h4);
        bus(1'b1, ISP_OFF_FLAGS, 32'h2);
        lock <= 1'b0;
        tick(2);
        rchk(ISP_OFF_FLAGS, 32'h2);
        bus(1'b1, ISP_OFF_FLAGS, 32'h2);
        bus(1'b1, ISP_OFF_ENABLE0, 32'h0);
        key_n <= 8'hef;
        tick(2);
        key_n <= 8'hff;
        rchk(ISP_OFF_PENDING, 32'h4000);
        bus(1'b1, ISP_OFF_FLAGS, 32'h100);
        bus(1'b1, ISP_OFF_ENABLE0, 32'h07fffefe);
        bus(1'b1, ISP_OFF_ENABLE1, 32'h3f);
        for (int i = 0; i < 25; i++)
        begin
            lv <= 25'h1 << i;
            tick(2);
            rchk(ISP_OFF_PENDING, 32'h1 << pb[i]);
        end
        lv <= 25'h1ffffff;
        bus(1'b1, ISP_OFF_ENABLE0, 32'h0);
        bus(1'b1, ISP_OFF_ENABLE1, 32'h0);
        rchk(ISP_OFF_PENDING, 32'h0);
        lv <= 25'h0;
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_ext();
        t_prio();
        t_misc();
        results();
    end
endmodule
